// ### logic/cdsf_defines.svh
// Purpose: constants of the serial control and status logic
// Assumes: frames shifted most significant bit first
// Notes: bit positions refer to the 16-bit data word of a frame
`ifndef CDSF_DEFINES_SVH
`define CDSF_DEFINES_SVH

// ============================================================
// frame lengths
`define CDSF_LEN_PLAIN 5'd16
`define CDSF_LEN_CRC 5'd24
`define CDSF_CNT_MAX 5'h1f
`define CDSF_SDO_START 5'd5

// ============================================================
// data word fields
`define CDSF_ADDR_HI 15
`define CDSF_ADDR_LO 13
`define CDSF_RD_BIT 12
`define CDSF_RANGE_HI 10
`define CDSF_RANGE_LO 7
`define CDSF_CLEAR_SCALE_SELECT_BIT 6
`define CDSF_OUTPUT_ON_BIT 5
`define CDSF_SENSE_RESISTOR_SELECT_BIT 4
`define CDSF_SWCLR_BIT 3
`define CDSF_RESET_BIT 2

// ============================================================
// readback fixed bits and crc
`define CDSF_RB_ONE 1'b1
`define CDSF_RB_ZERO 1'b0
`define CDSF_CRC_POLY 8'h07
`define CDSF_CRC_INIT 8'h00

// ============================================================
// reset values
`define CDSF_RST_RANGE 4'h0
`define CDSF_RST_CLEAR_SCALE_SELECT 1'b0
`define CDSF_RST_OUTPUT_ON 1'b0
`define CDSF_RST_SENSE_RESISTOR_SELECT 1'b0
`define CDSF_RST_SWCLR 1'b0

`endif

// ### logic/cdsf_pkg.sv
// Purpose: types of the serial control and status logic
// Assumes: nothing
// Notes: none
`default_nettype none
package cdsf_pkg;
    // ============================================================
    // operating settings
    typedef struct packed {
        logic [3:0] range_sel;
        logic clear_scale_select;
        logic output_on;
        logic sense_resistor_select;
        logic sw_clear;
    } cdsf_cfg_t;

    // ============================================================
    // readback snapshot handed to the link side
    typedef struct packed {
        logic rd_ok;
        logic [15:0] word;
    } cdsf_snap_t;

    // ============================================================
    // pins that cross into the core clock
    typedef struct packed {
        logic frame_sel_n;
        logic clear_in;
        logic clear_scale_pin;
        logic pin_config_select;
        logic [3:0] range_pins;
        logic sense_resistor_select_pin;
        logic [2:0] device_address;
        logic open_loop_det;
        logic overheat_det;
    } cdsf_pins_t;
endpackage : cdsf_pkg
`default_nettype wire

// ### logic/cdsf_sync2.sv
// Purpose: two flip-flop level synchroniser
// Assumes: quasi-static or single-bit levels
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module cdsf_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // ============================================================
    // synchroniser stages
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : cdsf_sync2
`default_nettype wire

// ### logic/cdsf_crc8.sv
// Purpose: crc-8 over a data word, polynomial x^8+x^2+x+1
// Assumes: data processed most significant bit first
// Notes: purely combinational
`timescale 1ns/1ps
`include "cdsf_defines.svh"
`default_nettype none
module cdsf_crc8 #(
    parameter int W = 16
) (
    input wire logic [W-1:0] data,
    output logic [7:0] crc
);
    logic [7:0] stage [0:W];

    assign stage[0] = `CDSF_CRC_INIT;

    // ============================================================
    // one step per data bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic fb;
            assign fb = stage[i][7] ^ data[W-1-i];
            assign stage[i+1] = {stage[i][6:0], 1'b0} ^ (fb ? `CDSF_CRC_POLY : 8'h00);
        end
    endgenerate

    assign crc = stage[W];
endmodule : cdsf_crc8
`default_nettype wire

// ### logic/cdsf_top.sv
// Purpose: serial control, status readback and fault alerts of a current driver
// Assumes: host keeps link_sclk still while frame_sel_n is high
// Notes: link logic runs on link_sclk, the rest on core_clk
//
// Overview of operation
// - frame addressing this device with read bit set is a status read.
// - serial_data_out stays disabled until an addressed read frame.
// - readback bits leave on serial_data_out from the fifth rising clock edge.
// - frame select going high disables serial_data_out again.
// - one read returns settings and status flags in one 16-bit word.
// - readback layout: address, 1, 0, range, clear scale, on, resistor, flags, 0.
// - bits 10 to 2 of a read frame still update the settings.
// - any of three read-only flags set in software mode pulls fault alert low.
// - crc failure of a frame sets the crc error flag.
// - over-temperature indication sets the overheat flag.
// - open-circuit detector sets the open-loop flag.
// - pin configuration strap high takes range and resistor from pins.
// - pin mode has no status; separate open-drain open-loop and overheat alerts.
// - software mode has one open-drain alert for open loop, crc, overheat.
// - clear input active high; forces clear value, release restores setting.
// - clear scale is OR of pin and bit; 0 zero scale, 1 midscale.
// - software clear bit in the control word also clears the output.
// - overrange settings come only from the four range bits or pins.
// - 24-bit frame checked at frame select rise; update only when it passes.
// - failed check discards frame, sets status bit 3, pulls fault alert low.
// - a status read clears the crc flag, releasing the alert if nothing else.
// - plain frame is 16 bits; input sampled on falling clock edges.
// - software mode enables current output only while the output-on bit is 1.
// - reset command bit returns all settings to their power-on state.
`timescale 1ns/1ps
`include "cdsf_defines.svh"
`default_nettype none
module cdsf_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_sclk,
    input wire logic frame_sel_n,
    input wire logic serial_data_in,
    output logic serial_data_out_o,
    output logic serial_data_out_oe,
    input wire logic [2:0] device_address,
    input wire logic pin_config_select,
    input wire logic [3:0] range_pins,
    input wire logic sense_resistor_select_pin,
    input wire logic clear_in,
    input wire logic clear_scale_pin,
    input wire logic open_loop_det,
    input wire logic overheat_det,
    output logic fault_alert_n_o,
    output logic fault_alert_n_oe,
    output logic open_loop_alert_n_o,
    output logic open_loop_alert_n_oe,
    output logic overheat_alert_n_o,
    output logic overheat_alert_n_oe,
    output cdsf_pkg::cdsf_cfg_t active_cfg,
    output logic clear_force,
    output logic clear_midscale,
    output logic [15:0] status_readback_word
);
    import cdsf_pkg::*;

    // ============================================================
    // declarations
    cdsf_pins_t pins_raw;
    cdsf_pins_t pins_s;
    cdsf_snap_t snap_r;
    cdsf_cfg_t cfg_r;
    cdsf_cfg_t cfg_nxt;
    cdsf_cfg_t cfg_rst;
    logic in_frame_r;
    logic [4:0] cnt_r;
    logic [23:0] sh_r;
    logic tog_r;
    logic tog_s;
    logic seen_tog_r;
    logic [15:0] out_sh_r;
    logic sdo_oe_r;
    logic fs_d_r;
    logic fs_rise;
    logic fs_fall;
    logic hw_mode_r;
    logic cap_done_r;
    logic [1:0] cap_wait_r;
    logic crc_err_r;
    logic open_loop_r;
    logic overheat_r;
    logic frame_new;
    logic len_plain;
    logic len_crc;
    logic [15:0] word;
    logic [7:0] crc_calc;
    logic crc_ok;
    logic addr_ok;
    logic accept;
    logic crc_fail;
    logic [15:0] rb_word;

    assign cfg_rst = '{range_sel: `CDSF_RST_RANGE, clear_scale_select: `CDSF_RST_CLEAR_SCALE_SELECT,
                       output_on: `CDSF_RST_OUTPUT_ON, sense_resistor_select: `CDSF_RST_SENSE_RESISTOR_SELECT,
                       sw_clear: `CDSF_RST_SWCLR};

    // ============================================================
    // link side: input shift on falling edges
    always_ff @(negedge link_sclk or posedge frame_sel_n) begin
        if (frame_sel_n) begin
            in_frame_r <= 1'b0;
        end else begin
            in_frame_r <= 1'b1;
        end
    end

    always_ff @(negedge link_sclk) begin
        sh_r <= {sh_r[22:0], serial_data_in};
    end

    always_ff @(negedge link_sclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 5'd0;
            tog_r <= 1'b0;
        end else if (!in_frame_r) begin
            cnt_r <= 5'd1;
            tog_r <= ~tog_r;
        end else if (cnt_r != `CDSF_CNT_MAX) begin
            cnt_r <= cnt_r + 5'd1;
        end
    end

    // ============================================================
    // link side: readback shift on rising edges
    always_ff @(posedge link_sclk or posedge frame_sel_n) begin
        if (frame_sel_n) begin
            sdo_oe_r <= 1'b0;
            out_sh_r <= 16'h0000;
        end else if (in_frame_r && cnt_r == `CDSF_SDO_START && snap_r.rd_ok && sh_r[1]
                     && sh_r[4:2] == snap_r.word[`CDSF_ADDR_HI:`CDSF_ADDR_LO]) begin
            sdo_oe_r <= 1'b1;
            out_sh_r <= snap_r.word;
        end else begin
            out_sh_r <= {out_sh_r[14:0], 1'b0};
        end
    end

    assign serial_data_out_o = out_sh_r[15];
    assign serial_data_out_oe = sdo_oe_r;

    // ============================================================
    // pin synchronisers
    assign pins_raw = '{frame_sel_n: frame_sel_n, clear_in: clear_in,
                        clear_scale_pin: clear_scale_pin, pin_config_select: pin_config_select,
                        range_pins: range_pins, sense_resistor_select_pin: sense_resistor_select_pin,
                        device_address: device_address, open_loop_det: open_loop_det,
                        overheat_det: overheat_det};

    cdsf_sync2 #(
        .W($bits(cdsf_pins_t))
    ) u_pin_sync (
        .clk(core_clk),
        .rst(rst),
        .d(pins_raw),
        .q(pins_s)
    );

    cdsf_sync2 #(
        .W(1)
    ) u_tog_sync (
        .clk(core_clk),
        .rst(rst),
        .d(tog_r),
        .q(tog_s)
    );

    // ============================================================
    // frame select edges
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fs_d_r <= 1'b1;
        end else begin
            fs_d_r <= pins_s.frame_sel_n;
        end
    end

    assign fs_rise = pins_s.frame_sel_n && !fs_d_r;
    assign fs_fall = !pins_s.frame_sel_n && fs_d_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            seen_tog_r <= 1'b0;
        end else if (fs_rise) begin
            seen_tog_r <= tog_s;
        end
    end

    // ============================================================
    // mode strap caught after reset release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hw_mode_r <= 1'b0;
            cap_done_r <= 1'b0;
            cap_wait_r <= 2'd0;
        end else if (!cap_done_r) begin
            // wait for the synchroniser to flush its reset value
            if (cap_wait_r == 2'd2) begin
                hw_mode_r <= pins_s.pin_config_select;
                cap_done_r <= 1'b1;
            end else begin
                cap_wait_r <= cap_wait_r + 2'd1;
            end
        end
    end

    // ============================================================
    // frame decode and crc check
    assign frame_new = fs_rise && (tog_s != seen_tog_r);
    assign len_plain = cnt_r == `CDSF_LEN_PLAIN;
    assign len_crc = cnt_r == `CDSF_LEN_CRC;
    assign word = len_crc ? sh_r[23:8] : sh_r[15:0];

    cdsf_crc8 #(
        .W(16)
    ) u_crc (
        .data(sh_r[23:8]),
        .crc(crc_calc)
    );

    assign crc_ok = crc_calc == sh_r[7:0];
    assign addr_ok = word[`CDSF_ADDR_HI:`CDSF_ADDR_LO] == pins_s.device_address;
    assign accept = frame_new && cap_done_r && !hw_mode_r && addr_ok
                    && (len_plain || (len_crc && crc_ok));
    assign crc_fail = frame_new && cap_done_r && !hw_mode_r && len_crc && !crc_ok;

    // ============================================================
    // settings register
    always_comb begin
        cfg_nxt = cfg_r;
        if (accept) begin
            if (word[`CDSF_RESET_BIT]) begin
                cfg_nxt = cfg_rst;
            end else begin
                cfg_nxt.range_sel = word[`CDSF_RANGE_HI:`CDSF_RANGE_LO];
                cfg_nxt.clear_scale_select = word[`CDSF_CLEAR_SCALE_SELECT_BIT];
                cfg_nxt.output_on = word[`CDSF_OUTPUT_ON_BIT];
                cfg_nxt.sense_resistor_select = word[`CDSF_SENSE_RESISTOR_SELECT_BIT];
                cfg_nxt.sw_clear = word[`CDSF_SWCLR_BIT];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_r <= cfg_rst;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ============================================================
    // status flags
    always_ff @(posedge core_clk) begin
        if (rst) begin
            crc_err_r <= 1'b0;
        end else if (crc_fail) begin
            crc_err_r <= 1'b1;
        end else if (accept && (word[`CDSF_RD_BIT] || word[`CDSF_RESET_BIT])) begin
            crc_err_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            open_loop_r <= 1'b0;
            overheat_r <= 1'b0;
        end else begin
            open_loop_r <= pins_s.open_loop_det;
            overheat_r <= pins_s.overheat_det;
        end
    end

    // ============================================================
    // readback word and snapshot at frame start
    assign rb_word = {pins_s.device_address, `CDSF_RB_ONE, `CDSF_RB_ZERO, cfg_r.range_sel,
                      cfg_r.clear_scale_select, cfg_r.output_on, cfg_r.sense_resistor_select,
                      crc_err_r, overheat_r, open_loop_r, `CDSF_RB_ZERO};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            snap_r <= '0;
        end else if (fs_fall) begin
            snap_r.rd_ok <= cap_done_r && !hw_mode_r;
            snap_r.word <= rb_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_readback_word <= 16'h0000;
        end else begin
            status_readback_word <= hw_mode_r ? 16'h0000 : rb_word;
        end
    end

    // ============================================================
    // alerts, open-drain
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_alert_n_oe <= 1'b0;
            open_loop_alert_n_oe <= 1'b0;
            overheat_alert_n_oe <= 1'b0;
        end else begin
            fault_alert_n_oe <= !hw_mode_r && (crc_err_r || open_loop_r
                                               || overheat_r);
            open_loop_alert_n_oe <= hw_mode_r && open_loop_r;
            overheat_alert_n_oe <= hw_mode_r && overheat_r;
        end
    end

    assign fault_alert_n_o = 1'b0;
    assign open_loop_alert_n_o = 1'b0;
    assign overheat_alert_n_o = 1'b0;

    // ============================================================
    // settings and clear to the output stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_cfg <= cfg_rst;
            clear_force <= 1'b0;
            clear_midscale <= 1'b0;
        end else begin
            if (hw_mode_r) begin
                active_cfg.range_sel <= pins_s.range_pins;
                active_cfg.sense_resistor_select <= pins_s.sense_resistor_select_pin;
                active_cfg.output_on <= 1'b1;
                active_cfg.clear_scale_select <= 1'b0;
                active_cfg.sw_clear <= 1'b0;
            end else begin
                active_cfg <= cfg_r;
                active_cfg.output_on <= cfg_r.output_on;
            end
            clear_force <= pins_s.clear_in || (!hw_mode_r && cfg_r.sw_clear);
            clear_midscale <= pins_s.clear_scale_pin
                              || (!hw_mode_r && cfg_r.clear_scale_select);
        end
    end
endmodule : cdsf_top
`default_nettype wire

// ### tb/cdsf_top_sva.sv
// Purpose: concurrent checks on the ports of cdsf_top
// Assumes: mode strap changes only under reset
// Notes: bound to every cdsf_top instance
`timescale 1ns/1ps
`default_nettype none
module cdsf_top_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_sclk,
    input wire logic frame_sel_n,
    input wire logic serial_data_out_oe,
    input wire logic pin_config_select,
    input wire logic clear_in,
    input wire logic open_loop_det,
    input wire logic overheat_det,
    input wire logic fault_alert_n_o,
    input wire logic fault_alert_n_oe,
    input wire logic open_loop_alert_n_o,
    input wire logic open_loop_alert_n_oe,
    input wire logic overheat_alert_n_o,
    input wire logic overheat_alert_n_oe,
    input wire cdsf_pkg::cdsf_cfg_t active_cfg,
    input wire logic clear_force,
    input wire logic [15:0] status_readback_word
);
    import cdsf_pkg::*;
    // ============================================================
    // helpers: cycles since reset, link rises in frame
    logic [3:0] run_r;
    logic [3:0] rise_r;
    always_ff @(posedge core_clk) begin
        if (rst) run_r <= 4'h0;
        else if (run_r != 4'hf) run_r <= run_r + 4'h1;
    end
    always_ff @(posedge link_sclk or posedge frame_sel_n) begin
        if (frame_sel_n) rise_r <= 4'h0;
        else if (rise_r != 4'hf) rise_r <= rise_r + 4'h1;
    end
    // ============================================================
    // checks
    sdo_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        frame_sel_n && $past(frame_sel_n) |-> !serial_data_out_oe) else $error("sdo driven while idle");
    sdo_late_a: assert property (@(negedge link_sclk) disable iff (rst)
        serial_data_out_oe |-> rise_r >= 4'h5) else $error("sdo driven too early");
    alert_on_a: assert property (@(posedge core_clk) disable iff (rst)
        (status_readback_word[3:1] != 3'h0) [*3] |-> fault_alert_n_oe) else $error("alert missing");
    alert_off_a: assert property (@(posedge core_clk) disable iff (rst)
        (status_readback_word[3:1] == 3'h0) [*3] |-> !fault_alert_n_oe) else $error("alert stuck");
    mode_split_a: assert property (@(posedge core_clk) disable iff (rst)
        pin_config_select ? !fault_alert_n_oe : !(open_loop_alert_n_oe || overheat_alert_n_oe))
        else $error("alert of wrong mode");
    pin_alert_a: assert property (@(posedge core_clk) disable iff (rst)
        pin_config_select && $rose(open_loop_det) |-> ##[2:6] open_loop_alert_n_oe) else $error("no pin alert");
    heat_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        !pin_config_select && $rose(overheat_det) |-> ##[2:6] status_readback_word[2]) else $error("no heat flag");
    pin_status_a: assert property (@(posedge core_clk) disable iff (rst)
        pin_config_select && run_r > 4'h6 |-> status_readback_word == 16'h0000 && active_cfg.output_on)
        else $error("pin mode state");
    clear_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        run_r > 4'h6 && clear_in && $past(clear_in, 4) |-> clear_force) else $error("clear not forced");
    od_drive_a: assert property (@(posedge core_clk) disable iff (rst)
        fault_alert_n_oe |-> !fault_alert_n_o) else $error("alert not pulled low");
    pin_od_a: assert property (@(posedge core_clk) disable iff (rst)
        !(open_loop_alert_n_oe && open_loop_alert_n_o) && !(overheat_alert_n_oe && overheat_alert_n_o))
        else $error("pin alert not pulled low");
endmodule : cdsf_top_sva
bind cdsf_top cdsf_top_sva i_cdsf_top_sva (.*);
`default_nettype wire

// ### tb/cdsf_host_model.sv
// Purpose: host side of the serial link
// Assumes: link clock idles high and stands still between frames
// Notes: readback bits sampled on falls 6 to 21
`timescale 1ns/1ps
`default_nettype none
module cdsf_host_model (
    output logic frame_sel_n,
    output logic link_sclk,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    logic [15:0] rx;
    initial begin
        frame_sel_n = 1'b0;
        link_sclk = 1'b1;
        serial_data_in = 1'b0;
        rx = 16'h0000;
        // power-up deselect edge clears the link side
        #1 frame_sel_n = 1'b1;
    end
    // ============================================================
    // one frame, 48 ns link period
    task automatic xfer(input logic [23:0] w, input int len);
        frame_sel_n = 1'b0;
        #100;
        for (int i = 0; i < len; i++) begin
            serial_data_in = w[len-1-i];
            #24 link_sclk = 1'b0;
            if (i > 4 && i < 21) rx = {rx[14:0], serial_data_out};
            #24 link_sclk = 1'b1;
        end
        #24 frame_sel_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #400;
    endtask : xfer
endmodule : cdsf_host_model
`default_nettype wire

// ### tb/tb_current_driver_serial_status_fault.sv
// Purpose: self-checking bench of the serial status and fault logic
// Assumes: host model drives the link
// Notes: reads use 24-bit frames so all 16 readback bits are seen
`timescale 1ns/1ps
`default_nettype none
module tb_current_driver_serial_status_fault;
    import cdsf_pkg::*;
    logic core_clk = 1'b1, rst = 1'b0, clear_in = 1'b0, clear_scale_pin = 1'b0;
    logic open_loop_det = 1'b0, overheat_det = 1'b0, pin_config_select = 1'b0, sense_resistor_select_pin = 1'b0;
    logic [2:0] dev_addr = 3'h5;
    logic [3:0] range_pins = 4'h0;
    wire frame_sel_n, link_sclk, serial_data_in, sdo_line;
    logic sdo_o, sdo_oe, fa_oe, ol_oe, oh_oe, clear_force, clear_midscale;
    cdsf_cfg_t active_cfg;
    logic [15:0] status_readback_word;
    int failures = 0, total_checks = 0, oe_hits = 0, h;
    assign sdo_line = sdo_oe ? sdo_o : ~sdo_o;
    cdsf_top i_cdsf_top (.core_clk(core_clk), .rst(rst), .link_sclk(link_sclk), .frame_sel_n(frame_sel_n),
        .serial_data_in(serial_data_in), .serial_data_out_o(sdo_o), .serial_data_out_oe(sdo_oe),
        .device_address(dev_addr), .pin_config_select(pin_config_select), .range_pins(range_pins),
        .sense_resistor_select_pin(sense_resistor_select_pin), .clear_in(clear_in), .clear_scale_pin(clear_scale_pin),
        .open_loop_det(open_loop_det), .overheat_det(overheat_det), .fault_alert_n_o(),
        .fault_alert_n_oe(fa_oe), .open_loop_alert_n_o(), .open_loop_alert_n_oe(ol_oe),
        .overheat_alert_n_o(), .overheat_alert_n_oe(oh_oe), .active_cfg(active_cfg),
        .clear_force(clear_force), .clear_midscale(clear_midscale), .status_readback_word(status_readback_word));
    cdsf_host_model u_host (.frame_sel_n(frame_sel_n), .link_sclk(link_sclk), .serial_data_in(serial_data_in),
        .serial_data_out(sdo_line));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge sdo_oe) oe_hits++;
    // ============================================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8
    function automatic logic [15:0] stw(input logic [6:0] s, input logic [2:0] f);
        return {dev_addr, 2'b10, s, f, 1'b0};
    endfunction : stw
    // mode 0 plain, 1 good crc, 2 bad crc
    task automatic send(input logic [2:0] a, input logic rd, input logic [6:0] s, input logic [3:0] x, input int m);
        logic [15:0] w;
        w = {a, rd, 1'b0, s, x};
        if (m == 0) u_host.xfer({8'h00, w}, 16);
        else u_host.xfer({w, crc8(w) ^ ((m == 2) ? 8'h01 : 8'h00)}, 24);
        @(negedge core_clk);
    endtask : send
    task automatic settle;
        repeat (8) @(negedge core_clk);
    endtask : settle
    task automatic do_reset(input logic pin);
        @(negedge core_clk);
        rst = 1'b1;
        pin_config_select = pin;
        settle();
        rst = 1'b0;
        settle();
    endtask : do_reset
    // ============================================================
    // scenarios
    task automatic t_power_on;
        do_reset(1'b0);
        chk({8'h00, active_cfg}, 16'h0000);
        chk(status_readback_word, stw(7'h00, 3'h0));
        chk({12'h000, sdo_oe, fa_oe, ol_oe, oh_oe}, 16'h0000);
    endtask : t_power_on
    task automatic t_write_read;
        h = oe_hits;
        send(dev_addr, 1'b0, 7'h4f, 4'h0, 0);
        chk({8'h00, active_cfg}, 16'h009e);
        chk({15'h0000, clear_midscale}, 16'h0001);
        chk(16'(oe_hits - h), 16'h0000);
        send(dev_addr, 1'b1, 7'h12, 4'h0, 1);
        chk(u_host.rx, stw(7'h4f, 3'h0));
        chk({8'h00, active_cfg}, 16'h0024);
        chk(16'(oe_hits - h), 16'h0001);
        chk({15'h0000, sdo_oe}, 16'h0000);
    endtask : t_write_read
    task automatic t_other_addr;
        h = oe_hits;
        send(dev_addr ^ 3'h7, 1'b1, 7'h7f, 4'h0, 1);
        chk({8'h00, active_cfg}, 16'h0024);
        chk(16'(oe_hits - h), 16'h0000);
    endtask : t_other_addr
    task automatic t_crc_faults;
        send(dev_addr, 1'b0, 7'h7d, 4'h0, 2);
        chk({8'h00, active_cfg}, 16'h0024);
        chk(status_readback_word, stw(7'h12, 3'h4));
        chk({15'h0000, fa_oe}, 16'h0001);
        send(dev_addr, 1'b0, 7'h7d, 4'h0, 1);
        chk(status_readback_word, stw(7'h7d, 3'h4));
        open_loop_det = 1'b1;
        settle();
        send(dev_addr, 1'b1, 7'h7d, 4'h0, 1);
        chk(u_host.rx, stw(7'h7d, 3'h5));
        chk(status_readback_word, stw(7'h7d, 3'h1));
        chk({15'h0000, fa_oe}, 16'h0001);
        open_loop_det = 1'b0;
        overheat_det = 1'b1;
        settle();
        chk(status_readback_word, stw(7'h7d, 3'h2));
        overheat_det = 1'b0;
        settle();
        chk(status_readback_word, stw(7'h7d, 3'h0));
        chk({15'h0000, fa_oe}, 16'h0000);
    endtask : t_crc_faults
    task automatic t_clear;
        clear_in = 1'b1;
        settle();
        chk({14'h0000, clear_force, clear_midscale}, 16'h0003);
        clear_in = 1'b0;
        settle();
        chk({14'h0000, clear_force, clear_midscale}, 16'h0001);
        send(dev_addr, 1'b0, 7'h02, 4'h8, 0);
        chk({8'h00, active_cfg}, 16'h0005);
        chk({14'h0000, clear_force, clear_midscale}, 16'h0002);
        clear_scale_pin = 1'b1;
        settle();
        chk({14'h0000, clear_force, clear_midscale}, 16'h0003);
        clear_scale_pin = 1'b0;
        send(dev_addr, 1'b0, 7'h7f, 4'h4, 0);
        chk({8'h00, active_cfg}, 16'h0000);
    endtask : t_clear
    task automatic t_pin_mode;
        range_pins = 4'ha;
        sense_resistor_select_pin = 1'b1;
        do_reset(1'b1);
        chk({9'h000, active_cfg.range_sel, active_cfg.output_on, active_cfg.sense_resistor_select,
            active_cfg.sw_clear}, 16'h0056);
        chk(status_readback_word, 16'h0000);
        open_loop_det = 1'b1;
        overheat_det = 1'b1;
        settle();
        chk({13'h0000, fa_oe, ol_oe, oh_oe}, 16'h0003);
        h = oe_hits;
        send(dev_addr, 1'b1, 7'h00, 4'h0, 1);
        chk(16'(oe_hits - h), 16'h0000);
        open_loop_det = 1'b0;
        overheat_det = 1'b0;
        settle();
        chk({13'h0000, fa_oe, ol_oe, oh_oe}, 16'h0000);
    endtask : t_pin_mode
    // ============================================================
    // run and verdict
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #2000000;
        failures++;
        final_report();
    end
    initial begin
        t_power_on();
        t_write_read();
        t_other_addr();
        t_crc_faults();
        t_clear();
        t_pin_mode();
        final_report();
    end
endmodule : tb_current_driver_serial_status_fault
`default_nettype wire
